/* File: rtl/light_conv_defines.vh */
// Constants for the two-channel light conversion and threshold interrupt block.
`ifndef LIGHT_CONV_DEFINES_VH
`define LIGHT_CONV_DEFINES_VH

`define CLK_MHZ          20
`define STEP_TIME_US     2700
`define STEP_CYCLES      (`STEP_TIME_US * `CLK_MHZ)
`define MAINS_STEPS      37
`define RESULT_W         16

`define ADDR_LOW         7'h29
`define ADDR_FLOAT       7'h39
`define ADDR_HIGH        7'h49
`define ADDR_ALERT_RESP  7'h0c

`define CMD_BIT          7
`define CMD_CLEAR_BIT    6
`define SEL_CH0_LO       4'h0
`define SEL_CH0_HI       4'h1
`define SEL_CH1_LO       4'h2
`define SEL_CH1_HI       4'h3

`define STRAP_WAIT       2'h3

`endif

/* File: rtl/pin_sync.v */
// Two-stage synchroniser with edge detection for asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rstn,
    // Raw pins and synchronised views
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise,
    output wire [WIDTH-1:0] fall
);
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] stable;
    reg [WIDTH-1:0] prev;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta   <= {WIDTH{1'b1}};
            stable <= {WIDTH{1'b1}};
            prev   <= {WIDTH{1'b1}};
        end else begin
            meta   <= din;
            stable <= meta;
            prev   <= stable;
        end
    end

    assign level = stable;
    assign rise  = stable & ~prev;
    assign fall  = ~stable & prev;
endmodule // pin_sync
`default_nettype wire

/* File: rtl/light_conversion_core.v */
// Conversion sequencer, threshold interrupt and two-wire slave of the light sensor.
`timescale 1ns/1ps
`default_nettype none
`include "light_conv_defines.vh"
module light_conversion_core #(
    parameter STEP_CYCLES = `STEP_CYCLES,
    parameter MAINS_STEPS = `MAINS_STEPS
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // Integrator charge quanta in, integrate and gain select out, same clock domain
    input  wire        ch0_quantum,
    input  wire        ch1_quantum,
    output reg         integrate,
    output reg  [1:0]  gain_sel,
    // Control inputs
    input  wire [7:0]  integration_cycle_count,
    input  wire [1:0]  gain_code,
    input  wire        mains_reject,
    input  wire [15:0] thresh_low,
    input  wire [15:0] thresh_high,
    input  wire [3:0]  persistence,
    input  wire        int_clear,
    input  wire        smb_variant,
    // Results and status
    output reg  [15:0] ch0_data,
    output reg  [15:0] ch1_data,
    output reg         conv_done,
    // Pins
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_o,
    output reg         sda_oe,
    output reg         int_o,
    output reg         int_oe,
    input  wire        addr_sel_hi,
    input  wire        addr_sel_lo
);
    localparam [6:0] S_IDLE = 7'h01, S_ADDR = 7'h02, S_AACK = 7'h04, S_WR = 7'h08,
                     S_WACK = 7'h10, S_RD = 7'h20, S_RACK = 7'h40;
    localparam [31:0] STEP_LAST_FULL  = STEP_CYCLES - 1;
    localparam [31:0] MAINS_LAST_FULL = MAINS_STEPS - 1;
    localparam [16:0] STEP_LAST       = STEP_LAST_FULL[16:0];
    localparam [5:0]  MAINS_LAST      = MAINS_LAST_FULL[5:0];

    wire [3:0] pin_level;
    wire [3:0] pin_rise;
    wire [3:0] pin_fall;

    pin_sync #(.WIDTH(4)) u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     ({addr_sel_lo, addr_sel_hi, sda_in, scl_in}),
        .level   (pin_level),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // Sequencer state.
    reg  [16:0] step_cnt;
    reg  [8:0]  steps;
    reg  [5:0]  phase;
    reg  [15:0] acc0;
    reg  [15:0] acc1;
    reg  [3:0]  persist_cnt;
    reg         pending;
    // Slave state.
    reg  [6:0]  state;
    reg  [3:0]  bitn;
    reg  [7:0]  shreg;
    reg  [7:0]  tx;
    reg         rw;
    reg         ara;
    reg         nacked;
    reg  [3:0]  reg_sel;
    reg  [7:0]  shadow_hi;
    reg  [6:0]  own_addr;
    reg  [1:0]  strap_wait;
    reg         cmd_clear;
    reg         ara_done;

    wire       step_tick = (step_cnt == STEP_LAST);
    wire [8:0] next_steps = steps + 9'h001;
    wire [5:0] next_phase = (phase == MAINS_LAST) ? 6'h00 : phase + 6'h01;
    wire [8:0] min_steps = (integration_cycle_count == 8'h00) ? 9'h001 : {1'b0, integration_cycle_count};
    wire       mains_ok = !mains_reject || (next_phase == 6'h00);
    wire       end_of_int = integrate && step_tick && (next_steps >= min_steps) && mains_ok;
    // The quantum of the closing cycle still belongs to this conversion.
    wire [15:0] next_acc0 = (ch0_quantum && acc0 != 16'hffff) ? acc0 + 16'h0001 : acc0;
    wire [15:0] next_acc1 = (ch1_quantum && acc1 != 16'hffff) ? acc1 + 16'h0001 : acc1;
    wire       out_of_range = (next_acc0 > thresh_high) || (next_acc0 < thresh_low);
    wire [3:0] next_persist = (persist_cnt == 4'hf) ? 4'hf : persist_cnt + 4'h1;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            integrate <= 1'b0;
            gain_sel  <= 2'h0;
            step_cnt  <= 17'h00000;
            steps     <= 9'h000;
            phase     <= 6'h00;
            acc0      <= 16'h0000;
            acc1      <= 16'h0000;
            ch0_data  <= 16'h0000;
            ch1_data  <= 16'h0000;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (!integrate) begin
                gain_sel  <= gain_code;
                integrate <= 1'b1;
                step_cnt  <= 17'h00000;
                steps     <= 9'h000;
                phase     <= 6'h00;
                acc0      <= 16'h0000;
                acc1      <= 16'h0000;
            end else if (end_of_int) begin
                ch0_data  <= next_acc0;
                ch1_data  <= next_acc1;
                conv_done <= 1'b1;
                integrate <= 1'b0;
            end else begin
                step_cnt <= step_tick ? 17'h00000 : step_cnt + 17'h00001;
                if (step_tick) begin
                    steps <= next_steps;
                    phase <= next_phase;
                end
                acc0 <= next_acc0;
                acc1 <= next_acc1;
            end
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            persist_cnt <= 4'h0;
            pending     <= 1'b0;
            int_oe      <= 1'b0;
            int_o       <= 1'b0;
        end else begin
            int_o <= 1'b0;
            if (end_of_int) begin
                if (out_of_range)
                    persist_cnt <= next_persist;
                else
                    persist_cnt <= 4'h0;
            end
            // Setting wins over any clear arriving in the same cycle.
            if (end_of_int && out_of_range && next_persist >= persistence)
                pending <= 1'b1;
            else if (int_clear || cmd_clear)
                pending <= 1'b0;
            else if (smb_variant && ara_done)
                pending <= 1'b0;
            int_oe <= pending;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            strap_wait <= 2'h0;
            own_addr   <= `ADDR_FLOAT;
        end else if (strap_wait != `STRAP_WAIT) begin
            strap_wait <= strap_wait + 2'h1;
            if (pin_level[2])
                own_addr <= `ADDR_HIGH;
            else if (pin_level[3])
                own_addr <= `ADDR_LOW;
            else
                own_addr <= `ADDR_FLOAT;
        end
    end

    wire scl_rise = pin_rise[0];
    wire scl_fall = pin_fall[0];
    wire sda      = pin_level[1];
    wire bus_start = pin_fall[1] && pin_level[0];
    wire bus_stop  = pin_rise[1] && pin_level[0];
    wire load_rd = scl_fall && (((state == S_AACK) && rw) || ((state == S_RACK) && !nacked));
    reg  [7:0] rd_byte;

    always @* begin
        rd_byte = 8'h00;
        if (ara)
            rd_byte = {own_addr, 1'b0};
        else case (reg_sel)
            `SEL_CH0_LO: rd_byte = ch0_data[7:0];
            `SEL_CH0_HI: rd_byte = shadow_hi;
            `SEL_CH1_LO: rd_byte = ch1_data[7:0];
            `SEL_CH1_HI: rd_byte = shadow_hi;
            default:     rd_byte = 8'h00;
        endcase
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state     <= S_IDLE;
            bitn      <= 4'h0;
            shreg     <= 8'h00;
            tx        <= 8'h00;
            rw        <= 1'b0;
            ara       <= 1'b0;
            nacked    <= 1'b0;
            reg_sel   <= 4'h0;
            shadow_hi <= 8'h00;
            sda_o     <= 1'b0;
            sda_oe    <= 1'b0;
            cmd_clear <= 1'b0;
            ara_done  <= 1'b0;
        end else begin
            cmd_clear <= 1'b0;
            ara_done  <= 1'b0;
            sda_o     <= 1'b0;
            if (bus_stop) begin
                state  <= S_IDLE;
                sda_oe <= 1'b0;
            end else if (bus_start) begin
                state  <= S_ADDR;
                bitn   <= 4'h0;
                sda_oe <= 1'b0;
            end else if (load_rd) begin
                // The whole coherent pair is taken when the low byte leaves.
                if (!ara && (reg_sel == `SEL_CH0_LO))
                    shadow_hi <= ch0_data[15:8];
                if (!ara && (reg_sel == `SEL_CH1_LO))
                    shadow_hi <= ch1_data[15:8];
                if (ara)
                    ara_done <= 1'b1;
                else
                    reg_sel <= reg_sel + 4'h1;
                sda_oe <= ~rd_byte[7];
                tx     <= {rd_byte[6:0], 1'b0};
                bitn   <= 4'h1;
                state  <= S_RD;
            end else if (scl_rise) begin
                if (state == S_ADDR || state == S_WR) begin
                    shreg <= {shreg[6:0], sda};
                    bitn  <= bitn + 4'h1;
                end else if (state == S_RACK) begin
                    nacked <= sda;
                end
            end else if (scl_fall) begin
                case (state)
                    S_ADDR: begin
                        if (bitn == 4'h8) begin
                            bitn <= 4'h0;
                            rw   <= shreg[0];
                            ara  <= 1'b0;
                            if (shreg[7:1] == own_addr) begin
                                sda_oe <= 1'b1;
                                state  <= S_AACK;
                            end else if (smb_variant && pending && shreg[0] &&
                                         shreg[7:1] == `ADDR_ALERT_RESP) begin
                                ara    <= 1'b1;
                                sda_oe <= 1'b1;
                                state  <= S_AACK;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_AACK: begin
                        sda_oe <= 1'b0;
                        state  <= S_WR;
                    end
                    S_WR: begin
                        if (bitn == 4'h8) begin
                            bitn <= 4'h0;
                            if (shreg[`CMD_BIT]) begin
                                reg_sel   <= shreg[3:0];
                                cmd_clear <= shreg[`CMD_CLEAR_BIT];
                            end
                            sda_oe <= 1'b1;
                            state  <= S_WACK;
                        end
                    end
                    S_WACK: begin
                        sda_oe <= 1'b0;
                        state  <= S_WR;
                    end
                    S_RD: begin
                        if (bitn == 4'h8) begin
                            sda_oe <= 1'b0;
                            state  <= S_RACK;
                        end else begin
                            sda_oe <= ~tx[7];
                            tx     <= {tx[6:0], 1'b0};
                            bitn   <= bitn + 4'h1;
                        end
                    end
                    S_RACK: begin
                        state <= S_IDLE;
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // light_conversion_core
`default_nettype wire

/* File: verification/light_conv_checker.sv */
// Port-level assertions for the light conversion core.
`timescale 1ns/1ps
`default_nettype none
module light_conv_checker #(
    parameter STEP_CYCLES = 20,
    parameter MAINS_STEPS = 3
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rstn,
    // Controls
    input wire logic [7:0]  integration_cycle_count,
    input wire logic [1:0]  gain_code,
    input wire logic        mains_reject,
    input wire logic        int_clear,
    input wire logic        scl_in,
    // Outputs
    input wire logic        integrate,
    input wire logic [1:0]  gain_sel,
    input wire logic        conv_done,
    input wire logic [15:0] ch0_data,
    input wire logic [15:0] ch1_data,
    input wire logic        sda_oe,
    input wire logic        sda_o,
    input wire logic        int_o,
    input wire logic        int_oe
);
    wire  [8:0] steps = (integration_cycle_count == 8'h00) ? 9'h001 : {1'b0, integration_cycle_count};
    int         hi_cnt;
    int         exp_len;
    logic       scl_d;
    logic [3:0] quiet;
    // A bus clear needs SCL activity, so holding is only judged once SCL has been still a while.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hi_cnt <= 0;
            exp_len <= 0;
            scl_d <= 1'b1;
            quiet <= 4'h0;
        end else begin
            hi_cnt <= integrate ? hi_cnt + 1 : 0;
            // The end of a conversion follows the live settings, so the expectation does too.
            exp_len <= STEP_CYCLES * (mains_reject ? (steps + MAINS_STEPS - 1) / MAINS_STEPS * MAINS_STEPS : steps);
            scl_d <= scl_in;
            quiet <= (scl_in != scl_d) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_done_restart: assert property (conv_done |-> !integrate ##1 integrate)
        else $error("integration did not restart after load");
    a_end_together: assert property ($fell(integrate) |-> conv_done)
        else $error("integration ended without a load");
    a_data_hold: assert property (!conv_done |-> $stable(ch0_data) && $stable(ch1_data))
        else $error("channel data changed outside a load");
    a_period_len: assert property (conv_done |-> hi_cnt == exp_len)
        else $error("integration length wrong");
    a_gain_take: assert property ($rose(integrate) && $past(conv_done) |-> gain_sel == $past(gain_code))
        else $error("gain not taken at conversion start");
    a_int_cause: assert property ($rose(int_oe) |-> $past(conv_done))
        else $error("interrupt raised without a load");
    a_int_hold: assert property (!int_clear ##1 (int_oe && !int_clear && quiet == 4'hf) |=> int_oe)
        else $error("interrupt dropped without a clear");
    a_int_clear: assert property (int_clear ##1 !conv_done |=> !int_oe)
        else $error("interrupt not released by clear");
    a_int_drain: assert property (int_oe |-> !int_o)
        else $error("interrupt pin not driven low");
    a_sda_drain: assert property (sda_oe |-> !sda_o)
        else $error("data pin not driven low");
    c_load: cover property (conv_done);
    c_int: cover property ($rose(int_oe));
    c_ack: cover property ($rose(sda_oe));
endmodule // light_conv_checker
`default_nettype wire

/* File: verification/bus_master_model.sv */
// Two-wire bus master model that drives SCL and pulls SDA low.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    // Wired data line
    input  wire logic sda_line,
    // Master drive
    output var  logic scl,
    output var  logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // SCL only moves inside frames and rests high between them.
    task automatic start_cond;
        sda_low = 1'b1;
        #200 scl = 1'b0;
    endtask
    task automatic stop_cond;
        sda_low = 1'b1;
        #100 scl = 1'b1;
        #100 sda_low = 1'b0;
        #400;
    endtask
    // Eight bits MSB first and the acknowledge slot; a released bit reads back the line.
    task automatic byte_io(input logic [7:0] d, input logic nack, output logic [7:0] r, output logic ack);
        logic [8:0] v;
        logic [8:0] s;
        v = {d, nack};
        for (int i = 8; i >= 0; i--) begin
            #100 sda_low = !v[i];
            #100 scl = 1'b1;
            #200 s[i] = sda_line;
            scl = 1'b0;
        end
        r = s[8:1];
        ack = s[0];
    endtask
endmodule // bus_master_model
`default_nettype wire

/* File: verification/dual_channel_light_conversion_irq_test.sv */
// Self-checking bench for the light conversion core.
`timescale 1ns/1ps
`default_nettype none
`include "light_conv_defines.vh"
module dual_channel_light_conversion_irq_test;
    localparam int STEP = 20;
    logic        clk_sys, rstn, q0, q1, clr, smb, hi, lo, mains, k;
    logic [7:0]  cnt;
    logic [1:0]  gain;
    logic [15:0] tl, th;
    logic [3:0]  pers;
    logic [7:0]  b [4];
    logic [6:0]  own [3] = '{`ADDR_HIGH, `ADDR_FLOAT, `ADDR_LOW};
    wire         integrate, conv_done, sda_o, sda_oe, int_o, int_oe, scl, sda_low;
    wire  [1:0]  gain_sel;
    wire  [15:0] ch0_data, ch1_data;
    // Pull-up on SDA: high unless a party pulls it.
    wire         sda_line = !(sda_oe || sda_low);
    int          fails = 0;
    int          n_tests = 0;
    light_conversion_core #(.STEP_CYCLES(STEP), .MAINS_STEPS(3)) light_conversion_core_inst (
        .clk_sys(clk_sys), .rstn(rstn), .ch0_quantum(q0), .ch1_quantum(q1), .integrate(integrate),
        .gain_sel(gain_sel), .integration_cycle_count(cnt), .gain_code(gain), .mains_reject(mains),
        .thresh_low(tl), .thresh_high(th), .persistence(pers), .int_clear(clr), .smb_variant(smb),
        .ch0_data(ch0_data), .ch1_data(ch1_data), .conv_done(conv_done), .scl_in(scl), .sda_in(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe), .addr_sel_hi(hi), .addr_sel_lo(lo));
    bus_master_model bus_master_model_inst (.sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    task automatic end_sim;
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_done(input int n);
        int i;
        repeat (n) begin
            i = 0;
            do begin
                @(negedge clk_sys);
                i++;
            end while (conv_done !== 1'b1 && i < 400);
            if (i >= 400) begin
                fails++;
                $display("[FAIL] %0t ns: no conversion", $time);
            end
        end
    endtask
    task automatic addr(input logic [6:0] a, input logic rd);
        bus_master_model_inst.start_cond();
        bus_master_model_inst.byte_io({a, rd}, 1'b1, b[0], k);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic ack);
        addr(a, 1'b0);
        chk({15'h0000, k}, {15'h0000, !ack});
        if (k == 1'b0)
            bus_master_model_inst.byte_io(c, 1'b1, b[0], k);
        bus_master_model_inst.stop_cond();
    endtask
    task automatic rd(input logic [6:0] a, input int n);
        addr(a, 1'b1);
        chk({15'h0000, k}, 16'h0000);
        for (int i = 0; i < n; i++)
            bus_master_model_inst.byte_io(8'hff, i == n - 1, b[i], k);
        bus_master_model_inst.stop_cond();
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        #3000000;
        fails++;
        end_sim();
    end
    initial begin
        rstn = 1'b0; q0 = 1'b1; q1 = 1'b0; clr = 1'b0; smb = 1'b0; hi = 1'b0; lo = 1'b0;
        mains = 1'b0; cnt = 8'h01; gain = 2'h2; tl = 16'h0000; th = 16'hffff; pers = 4'h2;
        for (int s = 0; s < 3; s++) begin
            @(posedge clk_sys);
            rstn <= 1'b0; hi <= (s == 0); lo <= (s == 2);
            repeat (6) @(posedge clk_sys);
            rstn <= 1'b1;
            repeat (8) @(posedge clk_sys);
            wr(own[s], 8'h80, 1'b1); // own address
            wr(own[(s + 1) % 3], 8'h80, 1'b0); // other level
        end
        wait_done(1);
        chk(ch0_data, 16'(STEP)); // channel zero
        chk(ch1_data, 16'h0000); // channel one
        chk({14'h0000, gain_sel}, 16'h0002); // gain applied
        @(posedge clk_sys);
        q0 <= 1'b0; q1 <= 1'b1; gain <= 2'h1;
        wait_done(2);
        chk(ch0_data, 16'h0000); // joint integration
        chk(ch1_data, 16'(STEP)); // joint integration
        chk({14'h0000, gain_sel}, 16'h0001); // new gain
        @(posedge clk_sys);
        q0 <= 1'b1; q1 <= 1'b0; cnt <= 8'h00;
        wait_done(2);
        chk(ch0_data, 16'(STEP)); // zero as one
        @(posedge clk_sys);
        mains <= 1'b1; cnt <= 8'h04;
        wait_done(2);
        chk(ch0_data, 16'(6 * STEP)); // rounded period
        @(posedge clk_sys);
        mains <= 1'b0; cnt <= 8'h01;
        wait_done(2);
        wr(`ADDR_LOW, 8'h80, 1'b1); // command byte
        rd(`ADDR_LOW, 4); // continuous reads
        chk({b[1], b[0]}, 16'(STEP)); // coherent pair
        chk({b[3], b[2]}, 16'h0000); // channel one
        @(posedge clk_sys);
        th <= 16'h000a;
        wait_done(1);
        @(negedge clk_sys);
        chk({15'h0000, int_oe}, 16'h0000); // persistence
        wait_done(1);
        @(negedge clk_sys);
        chk({15'h0000, int_oe}, 16'h0001); // upper threshold
        @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk({15'h0000, int_oe}, 16'h0000); // clear input
        wait_done(1);
        @(posedge clk_sys);
        th <= 16'hffff;
        repeat (60) @(negedge clk_sys);
        chk({15'h0000, int_oe}, 16'h0001); // level held
        wr(`ADDR_LOW, 8'hc0, 1'b1); // command clear
        @(negedge clk_sys);
        chk({15'h0000, int_oe}, 16'h0000); // bus clear
        @(posedge clk_sys);
        tl <= 16'h0005; q0 <= 1'b0;
        wait_done(3);
        @(negedge clk_sys);
        chk({15'h0000, int_oe}, 16'h0001); // lower threshold
        @(posedge clk_sys);
        tl <= 16'h0000; smb <= 1'b1;
        rd(`ADDR_ALERT_RESP, 1); // alert response
        chk({8'h00, b[0]}, {8'h00, `ADDR_LOW, 1'b0}); // responder address
        @(negedge clk_sys);
        chk({15'h0000, int_oe}, 16'h0000); // alert released
        end_sim();
    end
endmodule // dual_channel_light_conversion_irq_test
bind light_conversion_core light_conv_checker #(.STEP_CYCLES(STEP_CYCLES), .MAINS_STEPS(MAINS_STEPS)) light_conv_checker_inst (
    .clk_sys(clk_sys), .rstn(rstn), .integration_cycle_count(integration_cycle_count), .gain_code(gain_code),
    .mains_reject(mains_reject), .int_clear(int_clear), .scl_in(scl_in), .integrate(integrate), .gain_sel(gain_sel),
    .conv_done(conv_done), .ch0_data(ch0_data), .ch1_data(ch1_data), .sda_oe(sda_oe), .sda_o(sda_o), .int_o(int_o),
    .int_oe(int_oe));
`default_nettype wire
